/* File: sar_adc_parallel_host_control.sv */
// parallel host control of a 12-bit successive-approximation converter
//
// How it works
// - control byte on data pins 7..0: power mode, acquire, input, polarity, channel
// - chip select high ignores clock and strobes, data pins released
// - result is 12 bits, straight binary unipolar, two's complement bipolar
// - reset enters external clock mode, ready flag high, 10 us reset time
// - standby and shutdown keep the bus alive but stop conversions
// - standby wakes on the next write strobe rising edge
// - shutdown request converts once more and powers down when that word is done
// - write strobe rising edge leaves shutdown
// - codes step at half-LSB points, LSB is reference over 4096
// - unipolar spans common to reference; bipolar spans half reference each side
// - 17 cycles per sample: write, 3 acquire, 12 convert, read
// - prior result stays readable while the next acquisition runs
// - code 10 selects internal clock, code 11 the external clock pin
// - ready flag low at completion, high on first read or any write
// - acquire bit set opens acquisition; next write with bit clear converts
// - a write during conversion aborts it and starts a new acquisition
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_host_control
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned POR_COUNT = POR_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    chip_select_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    read_strobe_n,
  input  wire logic                    conv_clk_pin,
  input  wire logic [RESULT_WIDTH-1:0] data_in,
  output logic      [RESULT_WIDTH-1:0] data_out,
  output logic                         data_oe,
  output logic                         result_ready_n,
  input  wire logic                    cmp_above,
  output logic      [RESULT_WIDTH-1:0] dac_trial,
  output logic                         sample_hold,
  output logic      [2:0]              mux_sel,
  output logic                         single_or_diff_select,
  output logic                         polarity_select,
  output logic                         converter_powered,
  output logic                         reset_busy
);
  // refused at elaboration: a zero count would never release the bus
  if (POR_COUNT < 1) begin : g_por_check
    $error("por count must be at least one");
  end

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_ACQ_INT  = 5'b00010,
    ST_ACQ_EXT  = 5'b00100,
    ST_CONVERT  = 5'b01000,
    ST_SHUTDOWN = 5'b10000
  } conv_state_type;

  conv_state_type                 state;
  logic [CTRL_WIDTH-1:0]          conversion_control_byte;
  logic [1:0]                     clock_mode;
  logic                           wr_q;
  logic                           rd_q;
  logic                           clk_q;
  logic [4:0]                     div_cnt;
  logic [1:0]                     acq_cnt;
  logic [$clog2(POR_COUNT+1)-1:0] por_cnt;
  logic [RESULT_WIDTH-1:0]        result;
  logic                           seq_done;
  logic [RESULT_WIDTH-1:0]        seq_word;

  // chip select high masks every strobe and the clock pin
  wire sel       = ~chip_select_n;
  wire wr_rise   = sel & write_strobe_n & ~wr_q;
  wire rd_fall   = sel & ~read_strobe_n & rd_q;
  wire pm_lowpow = ~data_in[POWER_MODE_HI_BIT];
  wire [1:0] pm  = conversion_control_byte[POWER_MODE_HI_BIT:POWER_MODE_LO_BIT];
  wire pin_rise  = sel & conv_clk_pin & ~clk_q;
  wire int_tick  = (div_cnt == 5'(INT_CLK_DIV - 1));
  wire conv_tick = (clock_mode == PM_INT_CLK) ? int_tick : pin_rise;
  wire write_ok  = wr_rise && !reset_busy;
  wire start_conv;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q  <= 1'b1;
      rd_q  <= 1'b1;
      clk_q <= 1'b0;
    end else begin
      wr_q  <= write_strobe_n | chip_select_n;
      rd_q  <= read_strobe_n | chip_select_n;
      clk_q <= conv_clk_pin & sel;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      por_cnt    <= '0;
      reset_busy <= 1'b1;
    end else if (reset_busy) begin
      por_cnt <= por_cnt + 1'b1;
      if (por_cnt == ($bits(por_cnt))'(POR_COUNT - 1)) begin
        reset_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= int_tick ? 5'h00 : div_cnt + 5'h01;
    end
  end

  // byte latched at the strobe rising edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conversion_control_byte <= CTRL_RESET;
      clock_mode              <= PM_EXT_CLK;
    end else if (write_ok) begin
      conversion_control_byte <= data_in[CTRL_WIDTH-1:0];
      // low-power codes keep the last clock mode
      if (!pm_lowpow) begin
        clock_mode <= data_in[POWER_MODE_HI_BIT:POWER_MODE_LO_BIT];
      end
    end
  end

  assign mux_sel               = conversion_control_byte[MUX_SEL_MSB:0];
  assign single_or_diff_select = conversion_control_byte[SGL_DIFF_BIT];
  assign polarity_select       = conversion_control_byte[POLARITY_BIT];

  // acquisition and conversion sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      acq_cnt     <= '0;
      sample_hold <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_SHUTDOWN: begin
          // any write wakes from standby or shutdown
          if (write_ok) begin
            acq_cnt     <= '0;
            sample_hold <= 1'b0;
            state <= data_in[ACQ_HOLD_BIT] ? ST_ACQ_EXT : ST_ACQ_INT;
          end
        end
        ST_ACQ_INT: begin
          if (write_ok) begin
            acq_cnt <= '0;
            state   <= data_in[ACQ_HOLD_BIT] ? ST_ACQ_EXT : ST_ACQ_INT;
          end else if (conv_tick) begin
            if (acq_cnt == 2'(ACQ_CYCLES - 1)) begin
              sample_hold <= 1'b1;
              state       <= ST_CONVERT;
            end else begin
              acq_cnt <= acq_cnt + 2'h1;
            end
          end
        end
        ST_ACQ_EXT: begin
          if (write_ok) begin
            // bit cleared ends the open acquisition and starts conversion
            if (!data_in[ACQ_HOLD_BIT]) begin
              sample_hold <= 1'b1;
              state       <= ST_CONVERT;
            end
          end
        end
        ST_CONVERT: begin
          if (write_ok) begin
            sample_hold <= 1'b0;
            acq_cnt     <= '0;
            state <= data_in[ACQ_HOLD_BIT] ? ST_ACQ_EXT : ST_ACQ_INT;
          end else if (seq_done) begin
            sample_hold <= 1'b0;
            // shutdown only takes effect once the word is done
            state <= (pm == PM_SHUTDOWN) ? ST_SHUTDOWN : ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign start_conv = (state != ST_CONVERT) && (
    (state == ST_ACQ_INT && !write_ok && conv_tick && acq_cnt == 2'(ACQ_CYCLES - 1)) ||
    (state == ST_ACQ_EXT && write_ok && !data_in[ACQ_HOLD_BIT]));

  // standby and shutdown stop the converter, bus stays live
  assign converter_powered = (state != ST_SHUTDOWN) &&
                             !((state == ST_IDLE) && (pm == PM_STANDBY));

  sar_bit_sequencer #(
    .WIDTH (RESULT_WIDTH)
  ) u_seq (
    .core_clk  (core_clk),
    .rst       (rst),
    .start     (start_conv),
    .abort     (write_ok && state == ST_CONVERT),
    .step      (conv_tick),
    .cmp_above (cmp_above),
    .trial     (dac_trial),
    .busy      (),
    .done      (seq_done),
    .word      (seq_word)
  );

  // result held until the next completion, so it stays readable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result <= '0;
    end else if (seq_done && !write_ok) begin
      // bipolar: offset binary from the array flips msb to two's complement
      result <= polarity_select ? {~seq_word[RESULT_WIDTH-1], seq_word[RESULT_WIDTH-2:0]}
                                : seq_word;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_ready_n <= 1'b1;
    end else if (seq_done && !write_ok && state == ST_CONVERT) begin
      result_ready_n <= 1'b0;
    end else if (rd_fall || write_ok) begin
      result_ready_n <= 1'b1;
    end
  end

  // drive only while chip select and read strobe are both low
  assign data_oe  = sel & ~read_strobe_n;
  assign data_out = result;
endmodule : sar_adc_parallel_host_control
`default_nettype wire

/* File: sar_ctrl_pkg.sv */
// package: constants for the successive-approximation converter control block
package sar_ctrl_pkg;
  localparam int unsigned RESULT_WIDTH      = 12;
  localparam int unsigned CTRL_WIDTH        = 8;
  // control byte field positions
  localparam int unsigned POWER_MODE_HI_BIT = 7;
  localparam int unsigned POWER_MODE_LO_BIT = 6;
  localparam int unsigned ACQ_HOLD_BIT      = 5;
  localparam int unsigned SGL_DIFF_BIT      = 4;
  localparam int unsigned POLARITY_BIT      = 3;
  localparam int unsigned MUX_SEL_MSB       = 2;
  // power mode codes {hi,lo}, then the control byte loaded at reset
  localparam logic [1:0]  PM_STANDBY        = 2'h0;
  localparam logic [1:0]  PM_SHUTDOWN       = 2'h1;
  localparam logic [1:0]  PM_INT_CLK        = 2'h2;
  localparam logic [1:0]  PM_EXT_CLK        = 2'h3;
  localparam logic [7:0]  CTRL_RESET        = 8'hc0;
  // cycle counts in converter clocks
  localparam int unsigned ACQ_CYCLES        = 3;
  localparam int unsigned CONV_CYCLES       = 13;
  // power-on reset time, then the internal clock divider
  localparam int unsigned POR_TIME_NS       = 10000;
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned POR_CYCLES        = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_CLK_DIV       = 26;
endpackage : sar_ctrl_pkg

/* File: sar_bit_sequencer.sv */
// successive-approximation bit sequencer, one bit per converter clock
`timescale 1ns/1ps
`default_nettype none
module sar_bit_sequencer
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = RESULT_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             step,
  input  wire logic             cmp_above,
  output logic [WIDTH-1:0]      trial,
  output logic                  busy,
  output logic                  done,
  output logic [WIDTH-1:0]      word
);
  // refused at elaboration: one bit leaves nothing to approximate
  if (WIDTH < 2) begin : g_width_check
    $error("sar_bit_sequencer: width too small");
  end

  logic [WIDTH-1:0] bit_ptr;
  logic [WIDTH-1:0] acc;

  assign trial = acc | bit_ptr;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_ptr <= '0;
      acc     <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
      word    <= '0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy    <= 1'b0;
        bit_ptr <= '0;
      end else if (start) begin
        busy    <= 1'b1;
        acc     <= '0;
        bit_ptr <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (busy && step) begin
        // msb first: keep the trial bit when the input sits at or above it
        if (cmp_above) begin
          acc <= acc | bit_ptr;
        end
        bit_ptr <= bit_ptr >> 1;
        if (bit_ptr[0]) begin
          busy <= 1'b0;
          done <= 1'b1;
          word <= cmp_above ? (acc | bit_ptr) : acc;
        end
      end
    end
  end
endmodule : sar_bit_sequencer
`default_nettype wire

/* File: host_bus_model.sv */
// host processor model on the shared parallel bus
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import sar_ctrl_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic [RESULT_WIDTH-1:0] data_out,
  input  wire logic                    data_oe,
  output logic                         chip_select_n,
  output logic                         write_strobe_n,
  output logic                         read_strobe_n,
  output logic      [RESULT_WIDTH-1:0] data_in
);
  logic [RESULT_WIDTH-1:0] host_drv;
  // the shared wire: the device wins only while it is read
  assign data_in = data_oe ? data_out : host_drv;
  initial begin
    chip_select_n  = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n  = 1'b1;
    host_drv       = 12'h0a5;
  end
  task automatic edge_then(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : edge_then
  // select stays low when idle, else the masked clock pin stalls conversions
  task automatic write_byte(input logic [7:0] b, input logic sel_n);
    edge_then(1);
    chip_select_n  = sel_n;
    host_drv       = {4'h0, b};
    write_strobe_n = 1'b0;
    edge_then(2);
    write_strobe_n = 1'b1;
    edge_then(1);
    chip_select_n  = 1'b0;
    host_drv       = ~host_drv;
  endtask : write_byte
  task automatic read_word(input logic sel_n, output logic [RESULT_WIDTH-1:0] w,
                           output logic oe);
    edge_then(1);
    chip_select_n = sel_n;
    read_strobe_n = 1'b0;
    repeat (2) @(posedge core_clk);
    w  = data_in;
    oe = data_oe;
    #1;
    read_strobe_n = 1'b1;
    chip_select_n = 1'b0;
  endtask : read_word
endmodule : host_bus_model
`default_nettype wire

/* File: adc_ctrl_checker_sva.sv */
// port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker
  import sar_ctrl_pkg::*;
(
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    chip_select_n,
  input wire logic                    write_strobe_n,
  input wire logic                    read_strobe_n,
  input wire logic [RESULT_WIDTH-1:0] data_in,
  input wire logic [RESULT_WIDTH-1:0] data_out,
  input wire logic                    data_oe,
  input wire logic                    result_ready_n,
  input wire logic                    sample_hold,
  input wire logic [2:0]              mux_sel,
  input wire logic                    single_or_diff_select,
  input wire logic                    polarity_select,
  input wire logic                    converter_powered,
  input wire logic                    reset_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [4:0] cap;
  sequence wr_taken;
    !chip_select_n && !reset_busy && $rose(write_strobe_n);
  endsequence
  sequence rd_start;
    !chip_select_n && !result_ready_n && $fell(read_strobe_n);
  endsequence
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap <= 5'h00;
    end else if (!chip_select_n && !reset_busy && $rose(write_strobe_n)) begin
      cap <= data_in[4:0];
    end
  end
  AST_OE: assert property (data_oe == (!chip_select_n && !read_strobe_n))
    else $error("data drive does not follow select and read");
  AST_CS_MASK: assert property (chip_select_n && !result_ready_n && $fell(read_strobe_n)
    |=> !result_ready_n) else $error("deselected read cleared ready");
  AST_RD_CLR: assert property (rd_start |-> ##[1:2] result_ready_n)
    else $error("ready not cleared by read");
  AST_WR_CLR: assert property (wr_taken |-> ##[1:3] result_ready_n)
    else $error("ready not cleared by write");
  AST_RESET: assert property ($past(rst) |-> reset_busy && result_ready_n)
    else $error("wrong state after reset");
  AST_DATA_HOLD: assert property ($changed(data_out) |-> ##[0:1] !result_ready_n)
    else $error("result changed without completion");
  AST_HOLD_POWERED: assert property (sample_hold |-> converter_powered)
    else $error("conversion while powered down");
  AST_FIELDS: assert property (wr_taken ##3 1 |->
    {single_or_diff_select, polarity_select, mux_sel} == cap) else $error("fields not latched");
  AST_DONE_AFTER_HOLD: assert property ($fell(result_ready_n)
    |-> $past(sample_hold) || $past(sample_hold, 2)) else $error("result without conversion");
endmodule : adc_ctrl_checker
bind sar_adc_parallel_host_control adc_ctrl_checker chk (.core_clk, .rst, .chip_select_n,
  .write_strobe_n, .read_strobe_n, .data_in, .data_out, .data_oe, .result_ready_n,
  .sample_hold, .mux_sel, .single_or_diff_select, .polarity_select, .converter_powered,
  .reset_busy);
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sar_ctrl_pkg::*;
;
  localparam int unsigned POR_SMALL = 4;
  // 50 us settling after leaving shutdown, at 8 ns per clock
  localparam int unsigned SETTLE_CYCLES = 6250;
  logic core_clk, rst, conv_clk_pin, cmp_above, ext_run, oe;
  logic chip_select_n, write_strobe_n, read_strobe_n, data_oe, result_ready_n;
  logic sample_hold, single_or_diff_select, polarity_select, converter_powered, reset_busy;
  logic [RESULT_WIDTH-1:0] data_in, data_out, dac_trial, target, w;
  logic [2:0] mux_sel;
  int num_errors, check_count;
  // comparator: analog input held as an ideal code
  assign cmp_above = (dac_trial <= target);
  sar_adc_parallel_host_control #(.POR_COUNT(POR_SMALL)) dut (.core_clk, .rst,
    .chip_select_n, .write_strobe_n, .read_strobe_n, .conv_clk_pin, .data_in, .data_out,
    .data_oe, .result_ready_n, .cmp_above, .dac_trial, .sample_hold, .mux_sel,
    .single_or_diff_select, .polarity_select, .converter_powered, .reset_busy);
  host_bus_model host (.core_clk, .data_out, .data_oe, .chip_select_n, .write_strobe_n,
    .read_strobe_n, .data_in);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    conv_clk_pin = 1'b0;
    forever begin
      repeat (4) @(posedge core_clk);
      #1;
      if (ext_run) conv_clk_pin = ~conv_clk_pin;
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic wait_on(input int lim, input logic hold);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge core_clk);
      if ((hold ? sample_hold : !result_ready_n) === 1'b1) break;
    end
    #1;
    if (i == lim) begin
      num_errors++;
      $display("CHECK FAILED %0t wait ran out", $time);
      complete_run();
    end
  endtask : wait_on
  task automatic fetch(input logic [11:0] e);
    wait_on(1000, 1'b0);
    host.read_word(1'b0, w, oe);
    check(w, e, "result");
    check(oe, 1'b1, "drive");
    @(posedge core_clk);
    #1;
    check(result_ready_n, 1'b1, "ready after read");
  endtask : fetch
  task automatic s_modes();
    logic [7:0]  bt [5] = '{8'hcd, 8'hd2, 8'hc8, 8'hc0, 8'h8b};
    logic [11:0] tg [5] = '{12'h5a3, 12'hfff, 12'h000, 12'h000, 12'h800};
    // polarity bit set selects two's complement: code minus half scale
    logic [11:0] ex [5] = '{12'hda3, 12'hfff, 12'h800, 12'h000, 12'h000};
    for (int i = 0; i < 5; i++) begin
      // internal clock must convert with the pin standing still
      ext_run = bt[i][6];
      target = tg[i];
      host.write_byte(bt[i], 1'b0);
      wait_on(1000, 1'b0);
      check(mux_sel, bt[i][2:0], "channel");
      check(polarity_select, bt[i][3], "polarity");
      check(single_or_diff_select, bt[i][4], "input kind");
      fetch(ex[i]);
    end
    ext_run = 1'b1;
  endtask : s_modes
  task automatic s_cs_high();
    target = 12'h3c3;
    host.write_byte(8'hc0, 1'b0);
    wait_on(1000, 1'b0);
    host.write_byte(8'hcf, 1'b1);
    host.read_word(1'b1, w, oe);
    check(oe, 1'b0, "drive while deselected");
    check(result_ready_n, 1'b0, "ready kept");
    check(mux_sel, 3'h0, "byte ignored");
    fetch(12'h3c3);
  endtask : s_cs_high
  task automatic s_abort();
    target = 12'h123;
    host.write_byte(8'hc0, 1'b0);
    wait_on(400, 1'b1);
    repeat (30) @(posedge core_clk);
    #1;
    target = 12'h6b4;
    host.write_byte(8'hc1, 1'b0);
    fetch(12'h6b4);
  endtask : s_abort
  task automatic s_pipeline();
    target = 12'h9e1;
    host.write_byte(8'hc0, 1'b0);
    wait_on(1000, 1'b0);
    target = 12'h21d;
    host.write_byte(8'hc4, 1'b0);
    repeat (2) @(posedge core_clk);
    check(result_ready_n, 1'b1, "write clears ready");
    host.read_word(1'b0, w, oe);
    check(w, 12'h9e1, "prior result kept");
    fetch(12'h21d);
  endtask : s_pipeline
  task automatic s_power();
    logic [7:0] pm [2] = '{8'h40, 8'h00};
    for (int i = 0; i < 2; i++) begin
      target = 12'h47e;
      host.write_byte(8'he0, 1'b0);
      repeat (200) @(posedge core_clk);
      check(sample_hold, 1'b0, "acquisition open");
      host.write_byte(pm[i], 1'b0);
      fetch(12'h47e);
      check(converter_powered, 1'b0, "powered down");
      host.write_byte(8'hc0, 1'b0);
      repeat (2) @(posedge core_clk);
      check(converter_powered, 1'b1, "woken by write");
      if (i == 0) repeat (SETTLE_CYCLES) @(posedge core_clk);
      fetch(12'h47e);
    end
  endtask : s_power
  initial begin
    rst = 1'b1;
    target = 12'h000;
    ext_run = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check(result_ready_n, 1'b1, "ready at reset");
    check(reset_busy, 1'b1, "reset busy");
    repeat (POR_SMALL + 2) @(posedge core_clk);
    check(reset_busy, 1'b0, "reset over");
    s_modes();
    s_cs_high();
    s_abort();
    s_pipeline();
    s_power();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
